// [core/fbg_regs.svh]
`ifndef FBG_REGS_SVH
`define FBG_REGS_SVH

// =============================================================
// Register offsets on the three address lines
`define FBG_OFS_DIV_LOW      3'h0
`define FBG_OFS_DIV_HIGH     3'h1
`define FBG_OFS_DIV_FRAC     3'h2
`define FBG_OFS_MODEM_CTRL   3'h4
`define FBG_OFS_ENH_MODE     3'h5
`define FBG_OFS_GEN_STATUS   3'h7

// =============================================================
// Reset values
`define FBG_RST_DIV_LOW      8'h01
`define FBG_RST_DIV_HIGH     8'h00
`define FBG_RST_DIV_FRAC     8'h00
`define FBG_RST_MODEM_CTRL   8'h00
`define FBG_RST_ENH_MODE     8'h00

// =============================================================
// Field positions
`define FBG_BIT_PRESCALE     7
`define FBG_BIT_SAMPLE16     7
`define FBG_FRAC_MSB         3

// =============================================================
// Timing counts
`define FBG_PRESCALE_LAST    2'h3
`define FBG_OSR16_LAST       4'hF
`define FBG_OSR8_LAST        4'h7
`define FBG_OSR16_HALF       4'h7
`define FBG_OSR8_HALF        4'h3

`endif

// [core/fbg_pkg.sv]
package fbg_pkg;

    // Receive sampling timer phases
    typedef enum logic [1:0] {
        FBG_RX_IDLE,
        FBG_RX_HALF,
        FBG_RX_FULL
    } fbg_rx_state_t;

    typedef logic [7:0] fbg_byte_t;

endpackage

// [core/fbg_sync3.sv]
`timescale 1ns/1ps
`default_nettype none

// =============================================================
// Three-stage pin synchroniser with agreement filter
module fbg_sync3 #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // Stage one feeds stage two only; output moves once two and three agree
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            stage1 <= RST;
            stage2 <= RST;
            stage3 <= RST;
            q_out  <= RST;
        end else begin
            stage1 <= d_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                q_out <= stage3;
            end
        end
    end

endmodule

`default_nettype wire

// [core/fbg_chan_gen.sv]
`timescale 1ns/1ps
`default_nettype none

// =============================================================
// Prescaler plus fractional divider for one channel
module fbg_chan_gen
    import fbg_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        restart_in,
    input  wire logic        prescale_in,
    input  wire logic [15:0] div_int_in,
    input  wire logic [3:0]  div_frac_in,
    output logic             sample_tick_out,
    output logic      [3:0]  phase_out
);
`include "fbg_regs.svh"

    logic [1:0]  pre_cnt;
    logic [15:0] cnt;
    logic [3:0]  acc;
    wire         pre_tick;
    wire  [4:0]  acc_sum;
    wire  [15:0] base_last;
    wire  [15:0] next_cnt;
    wire         period_end;

    // Divide by four when the prescale bit is set, else pass every cycle
    assign pre_tick   = prescale_in ? (pre_cnt == `FBG_PRESCALE_LAST) : 1'b1;
    // Carry out of the sixteenths accumulator stretches one period
    assign acc_sum    = {1'b0, acc} + {1'b0, div_frac_in};
    // Integer zero behaves as one so the generator never stalls
    assign base_last  = (div_int_in == 16'h0000) ? 16'h0000 : div_int_in - 16'h0001;
    assign next_cnt   = base_last + {15'h0000, acc_sum[4]};
    assign period_end = pre_tick && (cnt == 16'h0000);

    // Prescaler counter
    always_ff @(posedge clk_in) begin
        if (!nrst_in || restart_in || !prescale_in) begin
            pre_cnt <= 2'h0;
        end else begin
            pre_cnt <= pre_cnt + 2'h1;
        end
    end

    // Period counter; any sixteen periods hold exactly frac stretches
    always_ff @(posedge clk_in) begin
        if (!nrst_in || restart_in) begin
            cnt <= 16'h0000;
            acc <= 4'h0;
        end else if (period_end) begin
            cnt <= next_cnt;
            acc <= acc_sum[3:0];
        end else if (pre_tick) begin
            cnt <= cnt - 16'h0001;
        end
    end

    // Registered sampling tick
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            sample_tick_out <= 1'b0;
        end else begin
            sample_tick_out <= period_end && !restart_in;
        end
    end

    assign phase_out = acc;

endmodule

`default_nettype wire

// [core/fbg_top.sv]
`timescale 1ns/1ps
`default_nettype none

module fbg_top
    import fbg_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       cs_a_n_in,
    input  wire logic       cs_b_n_in,
    input  wire logic       ior_n_in,
    input  wire logic       iow_n_in,
    input  wire logic [2:0] addr_in,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe_out,
    input  wire logic [1:0] rx_start_in,
    input  wire logic [1:0] rx_stop_in,
    output logic      [1:0] sample_tick_out,
    output logic      [1:0] tx_bit_tick_out,
    output logic      [1:0] rx_sample_tick_out
);
`include "fbg_regs.svh"

    // =============================================================
    // Host pin synchronisers
    // Limitation: the host bus is sampled on this clock, so register
    // access needs the clock running and lags the pins by a few cycles
    logic [3:0]  strobe_f;
    logic [10:0] busval_f;
    wire         cs_a_f;
    wire         cs_b_f;
    wire         ior_f;
    wire         iow_f;
    wire  [2:0]  addr_f;
    wire  [7:0]  wdata_f;

    // Strobes idle high, so they reset to ones
    fbg_sync3 #(
        .W   (4),
        .RST (4'hF)
    ) u_sync_strobe (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .d_in    ({cs_a_n_in, cs_b_n_in, ior_n_in, iow_n_in}),
        .q_out   (strobe_f)
    );

    fbg_sync3 #(
        .W   (11),
        .RST (11'h000)
    ) u_sync_bus (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .d_in    ({addr_in, data_in}),
        .q_out   (busval_f)
    );

    assign cs_a_f  = ~strobe_f[3];
    assign cs_b_f  = ~strobe_f[2];
    assign ior_f   = ~strobe_f[1];
    assign iow_f   = ~strobe_f[0];
    assign addr_f  = busval_f[10:8];
    assign wdata_f = busval_f[7:0];

    // =============================================================
    // Write capture: values taken while the strobe is low
    logic       iow_prev;
    logic [1:0] wr_sel;
    logic [2:0] wr_addr;
    logic [7:0] wr_data;
    wire        wr_commit;

    // Commit on the strobe's rising edge, when data has settled longest
    assign wr_commit = iow_prev && !iow_f;

    // Capture selects, address and data during the low phase
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            iow_prev <= 1'b0;
            wr_sel   <= 2'h0;
            wr_addr  <= 3'h0;
            wr_data  <= 8'h00;
        end else begin
            iow_prev <= iow_f;
            if (iow_f) begin
                wr_sel  <= {cs_b_f, cs_a_f};
                wr_addr <= addr_f;
                wr_data <= wdata_f;
            end
        end
    end

    // =============================================================
    // Per-channel registers and generators
    logic [1:0][7:0] rd_val;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            logic          [7:0] divisor_integer_low;
            logic          [7:0] divisor_integer_high;
            logic          [7:0] divisor_fraction;
            logic          [7:0] modem_control_register;
            logic          [7:0] enhanced_mode_register;
            logic                restart;
            logic          [3:0] tx_cnt;
            logic          [3:0] rx_cnt;
            fbg_rx_state_t       rx_state;
            fbg_rx_state_t       next_rx_state;
            wire                 wr_here;
            wire                 div_wr;
            wire                 sample16;
            wire           [3:0] bit_last;
            wire           [3:0] half_last;
            wire           [3:0] phase;
            wire                 tick;
            wire          [15:0] div_int;
            wire           [7:0] status;

            // Both selects low writes both channels at once
            assign wr_here   = wr_commit && wr_sel[ch];
            assign div_wr    = wr_here && (wr_addr == `FBG_OFS_DIV_LOW ||
                                           wr_addr == `FBG_OFS_DIV_HIGH ||
                                           wr_addr == `FBG_OFS_DIV_FRAC ||
                                           wr_addr == `FBG_OFS_MODEM_CTRL);
            assign div_int   = {divisor_integer_high, divisor_integer_low};
            assign sample16  = enhanced_mode_register[`FBG_BIT_SAMPLE16];
            assign bit_last  = sample16 ? `FBG_OSR16_LAST : `FBG_OSR8_LAST;
            assign half_last = sample16 ? `FBG_OSR16_HALF : `FBG_OSR8_HALF;

            // Register file; divisor defaults to exactly one
            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    divisor_integer_low    <= `FBG_RST_DIV_LOW;
                    divisor_integer_high   <= `FBG_RST_DIV_HIGH;
                    divisor_fraction       <= `FBG_RST_DIV_FRAC;
                    modem_control_register <= `FBG_RST_MODEM_CTRL;
                    enhanced_mode_register <= `FBG_RST_ENH_MODE;
                end else if (wr_here) begin
                    case (wr_addr)
                        `FBG_OFS_DIV_LOW: begin
                            divisor_integer_low <= wr_data;
                        end
                        `FBG_OFS_DIV_HIGH: begin
                            divisor_integer_high <= wr_data;
                        end
                        `FBG_OFS_DIV_FRAC: begin
                            // Upper four bits are not implemented
                            divisor_fraction <= {4'h0, wr_data[`FBG_FRAC_MSB:0]};
                        end
                        `FBG_OFS_MODEM_CTRL: begin
                            modem_control_register <= wr_data;
                        end
                        `FBG_OFS_ENH_MODE: begin
                            enhanced_mode_register <= wr_data;
                        end
                        default: begin
                        end
                    endcase
                end
            end

            // Restart the divider after a divisor or prescale change
            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    restart <= 1'b0;
                end else begin
                    restart <= div_wr;
                end
            end

            // Independent generator per channel
            fbg_chan_gen u_gen (
                .clk_in          (clk_in),
                .nrst_in         (nrst_in),
                .restart_in      (restart),
                .prescale_in     (modem_control_register[`FBG_BIT_PRESCALE]),
                .div_int_in      (div_int),
                .div_frac_in     (divisor_fraction[`FBG_FRAC_MSB:0]),
                .sample_tick_out (tick),
                .phase_out       (phase)
            );

            // Transmit bit timer: one bit every 16 or 8 ticks
            always_ff @(posedge clk_in) begin
                if (!nrst_in || restart) begin
                    tx_cnt <= 4'h0;
                end else if (tick) begin
                    tx_cnt <= (tx_cnt >= bit_last) ? 4'h0 : tx_cnt + 4'h1;
                end
            end

            // Receive timer steps from idle to mid-bit to whole bits
            always_comb begin
                next_rx_state = rx_state;
                case (rx_state)
                    FBG_RX_IDLE: begin
                        if (rx_start_in[ch]) begin
                            next_rx_state = FBG_RX_HALF;
                        end
                    end
                    FBG_RX_HALF: begin
                        if (tick && rx_cnt == half_last) begin
                            next_rx_state = FBG_RX_FULL;
                        end
                    end
                    FBG_RX_FULL: begin
                        next_rx_state = FBG_RX_FULL;
                    end
                    default: begin
                        next_rx_state = FBG_RX_IDLE;
                    end
                endcase
                // A stop request always wins and ends the frame
                if (rx_stop_in[ch]) begin
                    next_rx_state = FBG_RX_IDLE;
                end
            end

            // Receive counter and state
            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    rx_state <= FBG_RX_IDLE;
                    rx_cnt   <= 4'h0;
                end else begin
                    rx_state <= next_rx_state;
                    if (rx_state == FBG_RX_IDLE || rx_state != next_rx_state) begin
                        rx_cnt <= 4'h0;
                    end else if (tick) begin
                        rx_cnt <= (rx_cnt >= bit_last) ? 4'h0 : rx_cnt + 4'h1;
                    end
                end
            end

            // Registered tick outputs share the same sampling clock
            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    sample_tick_out[ch]    <= 1'b0;
                    tx_bit_tick_out[ch]    <= 1'b0;
                    rx_sample_tick_out[ch] <= 1'b0;
                end else begin
                    sample_tick_out[ch]    <= tick;
                    tx_bit_tick_out[ch]    <= tick && (tx_cnt == bit_last);
                    rx_sample_tick_out[ch] <= tick && !rx_stop_in[ch] &&
                        ((rx_state == FBG_RX_HALF && rx_cnt == half_last) ||
                         (rx_state == FBG_RX_FULL && rx_cnt == bit_last));
                end
            end

            // Status: fraction phase and receive activity
            assign status = {phase, 1'b0, 1'b0, sample16, rx_state != FBG_RX_IDLE};

            // Read selection for this channel
            assign rd_val[ch] =
                (addr_f == `FBG_OFS_DIV_LOW)    ? divisor_integer_low    :
                (addr_f == `FBG_OFS_DIV_HIGH)   ? divisor_integer_high   :
                (addr_f == `FBG_OFS_DIV_FRAC)   ? divisor_fraction       :
                (addr_f == `FBG_OFS_MODEM_CTRL) ? modem_control_register :
                (addr_f == `FBG_OFS_ENH_MODE)   ? enhanced_mode_register :
                (addr_f == `FBG_OFS_GEN_STATUS) ? status                 : 8'h00;
        end
    endgenerate

    // =============================================================
    // Read path
    wire       rd_active;
    wire [7:0] rd_mux;

    // Reading both channels together is illegal; channel A wins then
    assign rd_active = ior_f && (cs_a_f || cs_b_f);
    assign rd_mux    = cs_a_f ? rd_val[0] : rd_val[1];

    // Data is registered; bus drive follows the filtered read strobe
    // Costs one cycle of latency but keeps the read data free of glitches
    // while the address synchroniser settles
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            data_out    <= 8'h00;
            data_oe_out <= 1'b0;
        end else begin
            data_out    <= rd_active ? rd_mux : 8'h00;
            data_oe_out <= rd_active;
        end
    end

endmodule

`default_nettype wire

// [verif/fbg_top_props.sv]
`timescale 1ns/1ps
`default_nettype none

// =============================================================
// Port-level checks on the baud generator block
module fbg_top_props
    import fbg_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       cs_a_n_in,
    input  wire logic       cs_b_n_in,
    input  wire logic       ior_n_in,
    input  wire logic       iow_n_in,
    input  wire logic [1:0] rx_start_in,
    input  wire logic [1:0] rx_stop_in,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_out,
    input  wire logic [1:0] sample_tick_out,
    input  wire logic [1:0] tx_bit_tick_out,
    input  wire logic [1:0] rx_sample_tick_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    logic [4:0] ticks_seen;
    logic [1:0] clean;
    logic [5:0] ticks_now;

    // Sample ticks since the last bit tick, this cycle included
    assign ticks_now = {1'b0, ticks_seen} + {5'h00, sample_tick_out[0]};

    // Writes restart the divider, so three bit ticks pass before trusting the count
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !iow_n_in) begin
            ticks_seen <= 5'h00;
            clean      <= 2'h0;
        end else if (tx_bit_tick_out[0]) begin
            ticks_seen <= 5'h00;
            clean      <= (clean == 2'h3) ? clean : clean + 2'h1;
        end else begin
            ticks_seen <= ticks_now[4:0];
        end
    end

    sequence s_read_a;
        $fell(ior_n_in) && !cs_a_n_in;
    endsequence

    AST_RESET_QUIET: assert property ($rose(nrst_in) |-> !data_oe_out
        && data_out == 8'h00 && sample_tick_out == 2'b00 && tx_bit_tick_out == 2'b00)
        else $error("outputs not quiet after reset");
    AST_IDLE_BUS_ZERO: assert property (!data_oe_out |-> data_out == 8'h00)
        else $error("read data not zero while bus idle");
    AST_READ_ANSWER: assert property (s_read_a |-> ##[3:8] data_oe_out)
        else $error("no read answer");
    AST_OE_NEEDS_READ: assert property ($rose(data_oe_out) |-> !$past(ior_n_in, 2))
        else $error("bus driven without read strobe");
    AST_OE_RELEASE: assert property ($rose(ior_n_in) |-> ##[1:8] !data_oe_out)
        else $error("bus not released after read");
    AST_TX_PULSE: assert property (tx_bit_tick_out[0] |=> !tx_bit_tick_out[0])
        else $error("bit tick longer than one cycle");
    AST_TX_PULSE_B: assert property (tx_bit_tick_out[1] |=> !tx_bit_tick_out[1])
        else $error("channel b bit tick longer than one cycle");
    AST_BIT_RATIO: assert property (tx_bit_tick_out[0] && clean == 2'h3
        |-> ticks_now == 6'd8 || ticks_now == 6'd16)
        else $error("bit time not 8 or 16 sample ticks");
    AST_RX_STOP: assert property (rx_stop_in[0] |-> ##3 !rx_sample_tick_out[0] [*8])
        else $error("receive sampling after stop");
endmodule

bind fbg_top fbg_top_props u_props (
    .clk_in(clk_in), .nrst_in(nrst_in), .cs_a_n_in(cs_a_n_in), .cs_b_n_in(cs_b_n_in),
    .ior_n_in(ior_n_in), .iow_n_in(iow_n_in), .rx_start_in(rx_start_in),
    .rx_stop_in(rx_stop_in), .data_out(data_out), .data_oe_out(data_oe_out),
    .sample_tick_out(sample_tick_out), .tx_bit_tick_out(tx_bit_tick_out),
    .rx_sample_tick_out(rx_sample_tick_out)
);

`default_nettype wire

// [verif/test_fbg_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fbg_regs.svh"

// =============================================================
// Self-checking bench for the baud generator
module test_fbg_top
    import fbg_pkg::*;
;
    logic       clk_in   = 1'b0;
    logic       nrst_in  = 1'b0;
    logic [1:0] cs_n     = 2'b11;
    logic       ior_n    = 1'b1;
    logic       iow_n    = 1'b1;
    logic [2:0] addr     = 3'h0;
    fbg_byte_t  wdata    = 8'h00;
    logic [1:0] rx_start = 2'b00;
    logic [1:0] rx_stop  = 2'b00;
    logic       oe_prev  = 1'b0;
    logic [7:0] data_out;
    logic       data_oe_out;
    logic [1:0] tick;
    logic [1:0] txt;
    logic [1:0] rxt;
    int         fails    = 0;
    int         n_tests  = 0;
    integer     seed     = 43273;
    fbg_byte_t  exp_q[$];
    int         cn[4]    = '{2, 2, 1, 3};
    int         cf[4]    = '{5, 6, 0, 8};
    fbg_byte_t  cm[4]    = '{8'h00, 8'h00, 8'h80, 8'h00};
    fbg_byte_t  ce[4]    = '{8'h80, 8'h00, 8'h80, 8'h00};

    fbg_top u_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .cs_a_n_in(cs_n[0]), .cs_b_n_in(cs_n[1]),
        .ior_n_in(ior_n), .iow_n_in(iow_n), .addr_in(addr), .data_in(wdata),
        .data_out(data_out), .data_oe_out(data_oe_out), .rx_start_in(rx_start),
        .rx_stop_in(rx_stop), .sample_tick_out(tick), .tx_bit_tick_out(txt),
        .rx_sample_tick_out(rxt)
    );

    // 40 MHz clock
    always #12.5 clk_in = ~clk_in;

    // =============================================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    function automatic logic [1:0] cs_of(input int ch);
        return (ch != 0) ? 2'b01 : 2'b10;
    endfunction

    // Strobes are synchronised inside, so hold them well past the filter
    task automatic wr(input logic [1:0] cs, input logic [2:0] a, input fbg_byte_t d);
        @(negedge clk_in);
        cs_n = cs;
        addr = a;
        wdata = d;
        iow_n = 1'b0;
        repeat (6) @(negedge clk_in);
        iow_n = 1'b1;
        repeat (8) @(negedge clk_in);
        cs_n = 2'b11;
    endtask

    task automatic rd(input logic [1:0] cs, input logic [2:0] a, input fbg_byte_t e);
        @(negedge clk_in);
        exp_q.push_back(e);
        cs_n = cs;
        addr = a;
        ior_n = 1'b0;
        repeat (10) @(negedge clk_in);
        ior_n = 1'b1;
        repeat (8) @(negedge clk_in);
        cs_n = 2'b11;
    endtask

    task automatic prog(input int ch, input int n, input int f, input fbg_byte_t mc,
                        input fbg_byte_t em);
        wr(cs_of(ch), `FBG_OFS_DIV_HIGH, n[15:8]);
        wr(cs_of(ch), `FBG_OFS_DIV_LOW, n[7:0]);
        wr(cs_of(ch), `FBG_OFS_DIV_FRAC, f[7:0]);
        wr(cs_of(ch), `FBG_OFS_MODEM_CTRL, mc);
        wr(cs_of(ch), `FBG_OFS_ENH_MODE, em);
        repeat (20) @(negedge clk_in);
    endtask

    // Cycles from one event of a tick output to the k-th event after it
    task automatic measure(input int sel, input int ch, input int k, output int cyc);
        int   seen;
        int   lim;
        logic s;
        seen = -1;
        cyc = 0;
        lim = 0;
        while (seen < k && lim < 20000) begin
            @(negedge clk_in);
            lim++;
            s = (sel == 0) ? tick[ch] : (sel == 1) ? txt[ch] : rxt[ch];
            if (seen >= 0) cyc++;
            if (s === 1'b1) seen++;
        end
        if (lim >= 20000) fails++;
    endtask

    task automatic pulse(input int ch, input bit stop);
        @(negedge clk_in);
        if (stop) rx_stop[ch] = 1'b1;
        else rx_start[ch] = 1'b1;
        @(negedge clk_in);
        rx_stop = 2'b00;
        rx_start = 2'b00;
    endtask

    // Each read answer is matched against the oldest note
    always @(negedge clk_in) begin
        oe_prev <= data_oe_out;
        if (data_oe_out === 1'b1 && oe_prev !== 1'b1) begin
            if (exp_q.size() == 0) check("unexpected read", 32'h1, 32'h0);
            else check("read data", {24'h0, data_out}, {24'h0, exp_q.pop_front()});
        end
    end

    // Watchdog, well beyond the expected run length
    initial begin
        #500000;
        fails++;
        print_verdict();
    end

    // =============================================================
    // Main sequence
    initial begin
        int        n;
        int        f;
        int        c;
        int        k;
        fbg_byte_t hv[2];
        fbg_byte_t fv[2];
        repeat (12) @(negedge clk_in);
        nrst_in = 1'b1;
        repeat (4) @(negedge clk_in);
        measure(0, 0, 4, c);
        check("reset tick span", c, 4);
        measure(1, 0, 2, c);
        check("reset bit span", c, 16);
        for (int ch = 0; ch < 2; ch++) begin
            rd(cs_of(ch), `FBG_OFS_DIV_LOW, 8'h01);
            rd(cs_of(ch), `FBG_OFS_DIV_HIGH, 8'h00);
            rd(cs_of(ch), `FBG_OFS_DIV_FRAC, 8'h00);
        end
        // Random values; channels must keep their own copies
        for (int ch = 0; ch < 2; ch++) begin
            hv[ch] = 8'($random(seed));
            fv[ch] = 8'($random(seed));
            wr(cs_of(ch), `FBG_OFS_DIV_HIGH, hv[ch]);
            wr(cs_of(ch), `FBG_OFS_DIV_FRAC, fv[ch]);
        end
        for (int ch = 0; ch < 2; ch++) begin
            rd(cs_of(ch), `FBG_OFS_DIV_HIGH, hv[ch]);
            rd(cs_of(ch), `FBG_OFS_DIV_FRAC, fv[ch] & 8'h0F);
        end
        wr(2'b00, `FBG_OFS_DIV_LOW, 8'h5A);
        rd(2'b01, `FBG_OFS_DIV_LOW, 8'h5A);
        wr(2'b10, `FBG_OFS_DIV_LOW, 8'h33);
        rd(2'b00, `FBG_OFS_DIV_LOW, 8'h33);
        wr(2'b10, 3'h3, 8'hFF);
        wr(2'b10, 3'h6, 8'hFF);
        rd(2'b10, 3'h3, 8'h00);
        rd(2'b10, 3'h6, 8'h00);
        // Sixteen periods hold exactly f stretched ones
        for (int ch = 0; ch < 2; ch++) begin
            n = 2 + ($random(seed) & 3);
            f = $random(seed) & 15;
            prog(ch, n, f, 8'h00, 8'h00);
            measure(0, ch, 16, c);
            check("sixteen periods", c, 16 * n + f);
        end
        prog(0, 3, 0, 8'h80, 8'h00);
        measure(0, 0, 2, c);
        check("prescaled periods", c, 24);
        prog(0, 16'h0100, 0, 8'h00, 8'h00);
        measure(0, 0, 1, c);
        check("high byte period", c, 256);
        // Bit times must not jitter outside 8X with an odd fraction
        for (int i = 0; i < 4; i++) begin
            k = ce[i][7] ? 16 : 8;
            prog(0, cn[i], cf[i], cm[i], ce[i]);
            for (int j = 0; j < 2; j++) begin
                measure(1, 0, 1, c);
                check("bit time", c, (cm[i][7] ? 4 : 1) * (k * cn[i] + k * cf[i] / 16));
            end
        end
        // Receive sampling one bit apart, 8X on channel a, 16X on b
        for (int ch = 0; ch < 2; ch++) begin
            prog(ch, 1, 0, 8'h00, (ch != 0) ? 8'h80 : 8'h00);
            pulse(ch, 1'b0);
            measure(2, ch, 2, c);
            check("receive sample span", c, (ch != 0) ? 32 : 16);
            // Status shows the sampling factor and an active receive timer
            rd(cs_of(ch), `FBG_OFS_GEN_STATUS, (ch != 0) ? 8'h03 : 8'h01);
            pulse(ch, 1'b1);
            repeat (20) @(negedge clk_in);
            rd(cs_of(ch), `FBG_OFS_GEN_STATUS, (ch != 0) ? 8'h02 : 8'h00);
        end
        print_verdict();
    end
endmodule

`default_nettype wire
